// [rtl/mfr_read_front.sv]
/*
  Command front-end for dual and quad I/O fast reads, single and double
  rate, with continuation mode and wrap-around quad bursts, plus the wrap
  setting command. Assumes the pins are asynchronous to mclk and that
  sclk runs well below mclk/8 so each sclk level lasts 4+ mclk cycles;
  the memory array answers fetch requests in order, one byte each.
*/
`timescale 1ns/10ps
`include "mfr_regs.svh"

// Contract
// RQ1 - BBh takes address two bits per clock, returns data on IO0 and IO1.
// RQ2 - eight-bit continuation byte follows address; only upper nibble matters.
// RQ3 - continuation bits 10 make next select-low period skip opcode.
// RQ4 - any other continuation value restores normal opcode decoding.
// RQ5 - host releases IO lines before first data-out falling edge.
// RQ6 - dual exit: sixteen clocks of ones on IO0.
// RQ7 - BDh is dual I/O read with address and data at double rate.
// RQ8 - double-rate dual exit: ones on IO0 for sixteen or twenty clocks.
// RQ9 - EBh moves address and data on four lines, four dummy clocks.
// RQ10 - quad reads accepted only while quad permit bit is one; continuation entries skip this check.
// RQ11 - quad exit: eight clocks of ones on IO0.
// RQ12 - EDh is quad I/O read at double rate, four dummy clocks.
// RQ13 - double-rate quad exit: ones on IO0 for eight or ten clocks.
// RQ14 - wrap enabled confines quad reads to aligned section of page.
// RQ15 - wrap output starts at address, returns to section start, repeats.
// RQ16 - wrap bit 4 enables wrapping, bits 6 and 5 pick length; code wraps while bit 4 is zero.
// RQ17 - wrap command: 77h, 24 dummy bits, then wrap byte.
// RQ18 - wrap disable bit resets to one; writing one restores linear reads.
// RQ19 - double rate: address and data on both edges, opcode single rate.
// RQ20 - wrap length 00, 01, 10, 11 selects 8, 16, 32, 64 bytes.
// RQ21 - continuation remembers read kind and repeats it without opcode.
module mfr_read_front (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // flash pins
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic [3:0] spi_io_in,
  output mfr_pkg::mfr_pins_s spi_io_drive,
  // configuration and status
  input wire logic quad_io_permit_bit,
  output logic [2:0] wrap_setting_bits,
  output logic continuation_active,
  // memory array fetch
  output mfr_pkg::mfr_req_s mem_req,
  input wire logic mem_req_ready,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rdata_valid,
  output logic mem_rdata_ready
);
  logic cs_s1, cs_s2, cs_prev, ck_s1, ck_s2, ck_prev;
  logic [3:0] io_s1, io_s2;
  logic rise, fall, cs_high, cs_fall, cs_rise, samp_in, out_edge, adv;
  mfr_pkg::mfr_state_e state, next_state;
  mfr_pkg::mfr_kind_e kind, cont_kind, op_kind;
  logic quad, dtr, op_read, op_quad, wrap_on, fetching;
  logic [4:0] unit_cnt, addr_units, mode_units, byte_units, dummy_clks;
  logic [4:0] dum_seen, credit_need;
  logic [7:0] opcode, op_next, mode_byte, mode_next, wrap_shift, wrap_next;
  logic [7:0] out_byte, cur_byte, fifo_data;
  logic [23:0] read_addr, addr_next, inc_addr, step_addr;
  logic [5:0] wrap_mask;
  logic [3:0] pend, drop, fifo_level;
  logic req_fire, rd_fire, push, pop, fifo_out_valid, fifo_in_ready;

  // two flops on every pin before anything looks at it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_prev <= 1'b1;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_prev <= 1'b0;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end else begin
      cs_s1 <= spi_cs_n;
      cs_s2 <= cs_s1;
      cs_prev <= cs_s2;
      ck_s1 <= spi_sclk;
      ck_s2 <= ck_s1;
      ck_prev <= ck_s2;
      io_s1 <= spi_io_in;
      io_s2 <= io_s1;
    end
  end

  assign rise = ck_s2 & ~ck_prev;
  assign fall = ~ck_s2 & ck_prev;
  assign cs_high = cs_s2;
  assign cs_fall = ~cs_s2 & cs_prev;
  assign cs_rise = cs_s2 & ~cs_prev;
  // double-rate address opens on a rise: the fall after the opcode is not data
  assign samp_in = rise | (dtr & fall & ~(state == mfr_pkg::ST_ADDR && unit_cnt == 5'h00)); // [RQ19]
  assign out_edge = fall | (dtr & rise); // [RQ19]

  always_comb begin
    quad = (kind == mfr_pkg::K_QUAD) || (kind == mfr_pkg::K_QUAD_DTR);
    dtr = (kind == mfr_pkg::K_DUAL_DTR) || (kind == mfr_pkg::K_QUAD_DTR); // [RQ7] [RQ12]
    addr_units = quad ? `MFR_ADDR_UNITS_QUAD : `MFR_ADDR_UNITS_DUAL; // [RQ1] [RQ9]
    mode_units = quad ? `MFR_MODE_UNITS_QUAD : `MFR_MODE_UNITS_DUAL;
    byte_units = quad ? `MFR_BYTE_UNITS_QUAD : `MFR_BYTE_UNITS_DUAL;
    case (kind)
      mfr_pkg::K_DUAL: dummy_clks = `MFR_DUMMY_DUAL;
      mfr_pkg::K_DUAL_DTR: dummy_clks = `MFR_DUMMY_DUAL_DTR;
      mfr_pkg::K_QUAD: dummy_clks = `MFR_DUMMY_QUAD; // [RQ9]
      default: dummy_clks = `MFR_DUMMY_QUAD_DTR; // [RQ12]
    endcase
  end

  // opcode is always one bit per rising edge on IO0
  assign op_next = {opcode[6:0], io_s2[0]}; // [RQ19]
  assign addr_next = quad ? {read_addr[19:0], io_s2} : {read_addr[21:0], io_s2[1:0]};
  assign mode_next = quad ? {mode_byte[3:0], io_s2} : {mode_byte[5:0], io_s2[1:0]};
  assign wrap_next = {wrap_shift[3:0], io_s2};

  always_comb begin
    op_kind = mfr_pkg::K_DUAL;
    op_read = 1'b1;
    if (op_next == `MFR_OP_DUAL) begin
      op_kind = mfr_pkg::K_DUAL; // [RQ1]
    end else if (op_next == `MFR_OP_DUAL_DTR) begin
      op_kind = mfr_pkg::K_DUAL_DTR; // [RQ7]
    end else if (op_next == `MFR_OP_QUAD) begin
      op_kind = mfr_pkg::K_QUAD; // [RQ9]
    end else if (op_next == `MFR_OP_QUAD_DTR) begin
      op_kind = mfr_pkg::K_QUAD_DTR; // [RQ12]
    end else begin
      op_read = 1'b0;
    end
  end
  assign op_quad = (op_kind == mfr_pkg::K_QUAD) || (op_kind == mfr_pkg::K_QUAD_DTR);

  always_comb begin
    next_state = state;
    if (cs_high) begin
      next_state = mfr_pkg::ST_IDLE;
    end else begin
      case (state)
        mfr_pkg::ST_IDLE: begin
          if (cs_fall) begin
            next_state = continuation_active ? mfr_pkg::ST_ADDR : mfr_pkg::ST_OPCODE; // [RQ3] [RQ4]
          end
        end
        mfr_pkg::ST_OPCODE: begin
          if (rise && unit_cnt == `MFR_OPCODE_UNITS - 5'h01) begin
            if (op_read && (!op_quad || quad_io_permit_bit)) begin
              next_state = mfr_pkg::ST_ADDR; // [RQ10]
            end else if (op_next == `MFR_OP_WRAP_SET) begin
              next_state = mfr_pkg::ST_WRAP_SKIP; // [RQ17]
            end else begin
              next_state = mfr_pkg::ST_IGNORE;
            end
          end
        end
        mfr_pkg::ST_ADDR: begin
          if (samp_in && unit_cnt == addr_units - 5'h01) begin
            next_state = mfr_pkg::ST_MODE; // [RQ2]
          end
        end
        mfr_pkg::ST_MODE: begin
          if (samp_in && unit_cnt == mode_units - 5'h01) begin
            next_state = (dummy_clks == 5'h00) ? mfr_pkg::ST_DATA : mfr_pkg::ST_DUMMY;
          end
        end
        mfr_pkg::ST_DUMMY: begin
          if (rise && unit_cnt == dummy_clks - 5'h01) begin
            next_state = mfr_pkg::ST_DATA; // [RQ9] [RQ12]
          end
        end
        mfr_pkg::ST_WRAP_SKIP: begin
          if (rise && unit_cnt == `MFR_WRAP_SKIP_UNITS - 5'h01) begin
            next_state = mfr_pkg::ST_WRAP_BYTE;
          end
        end
        mfr_pkg::ST_WRAP_BYTE: begin
          if (rise && unit_cnt == `MFR_WRAP_BYTE_UNITS - 5'h01) begin
            next_state = mfr_pkg::ST_IGNORE;
          end
        end
        default: next_state = state;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= mfr_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    if (state == mfr_pkg::ST_ADDR || state == mfr_pkg::ST_MODE) begin
      adv = samp_in;
    end else if (state == mfr_pkg::ST_DATA) begin
      adv = out_edge;
    end else begin
      adv = rise;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || next_state != state) begin
      unit_cnt <= 5'h00;
    end else if (adv) begin
      unit_cnt <= (state == mfr_pkg::ST_DATA && unit_cnt == byte_units - 5'h01) ?
        5'h00 : unit_cnt + 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      opcode <= 8'h00;
      read_addr <= 24'h000000;
      mode_byte <= 8'h00;
      wrap_shift <= 8'h00;
    end else begin
      if (state == mfr_pkg::ST_OPCODE && rise) opcode <= op_next;
      if (state == mfr_pkg::ST_ADDR && samp_in) read_addr <= addr_next; // [RQ1] [RQ9]
      if (state == mfr_pkg::ST_MODE && samp_in) mode_byte <= mode_next;
      if (state == mfr_pkg::ST_WRAP_BYTE && rise) wrap_shift <= wrap_next;
    end
  end

  // read kind: a fresh opcode, or the remembered one on an opcode-less entry
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      kind <= mfr_pkg::K_DUAL;
    end else if (state == mfr_pkg::ST_OPCODE && next_state == mfr_pkg::ST_ADDR) begin
      kind <= op_kind;
    end else if (state == mfr_pkg::ST_IDLE && next_state == mfr_pkg::ST_ADDR) begin
      kind <= cont_kind; // [RQ21]
    end
  end

  // only bits 5:4 of the continuation byte are looked at
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      continuation_active <= 1'b0;
      cont_kind <= mfr_pkg::K_DUAL;
    end else if (state == mfr_pkg::ST_MODE && samp_in && unit_cnt == mode_units - 5'h01) begin
      continuation_active <= (mode_next[`MFR_CONT_SEL_LO +: 2] == `MFR_CONT_SEL_KEEP); // [RQ2] [RQ3] [RQ4]
      cont_kind <= kind; // [RQ21]
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrap_setting_bits <= `MFR_WRAP_RESET; // [RQ18]
    end else if (state == mfr_pkg::ST_WRAP_BYTE && rise &&
                 unit_cnt == `MFR_WRAP_BYTE_UNITS - 5'h01) begin
      wrap_setting_bits <= wrap_next[`MFR_WRAP_FIELD_LO +: 3]; // [RQ16] [RQ18]
    end
  end

  always_comb begin
    case (wrap_setting_bits[2:1])
      2'b00: wrap_mask = `MFR_WRAP_MASK_8; // [RQ20]
      2'b01: wrap_mask = `MFR_WRAP_MASK_16;
      2'b10: wrap_mask = `MFR_WRAP_MASK_32;
      default: wrap_mask = `MFR_WRAP_MASK_64;
    endcase
  end

  assign wrap_on = ~wrap_setting_bits[0] & quad; // [RQ14] [RQ16]
  assign inc_addr = mem_req.addr + 24'h000001;
  // wrapping keeps the bits above the section, so the page is never left
  assign step_addr = wrap_on ?
    {mem_req.addr[23:6], (mem_req.addr[5:0] & ~wrap_mask) | (inc_addr[5:0] & wrap_mask)} :
    inc_addr; // [RQ14] [RQ15]

  assign fetching = (state == mfr_pkg::ST_MODE) || (state == mfr_pkg::ST_DUMMY) ||
    (state == mfr_pkg::ST_DATA);
  assign req_fire = mem_req.valid & mem_req_ready;
  assign rd_fire = mem_rdata_valid & fifo_in_ready;
  assign credit_need = 5'({1'b0, pend}) + 5'({1'b0, fifo_level}) + (req_fire ? 5'h02 : 5'h01);

  // prefetch only as far as the buffer can hold every byte in flight
  always_ff @(posedge mclk) begin
    if (sys_rst || cs_high) begin
      mem_req.valid <= 1'b0;
    end else if (!mem_req.valid || mem_req_ready) begin
      mem_req.valid <= fetching && !cs_rise && (credit_need <= 5'(`MFR_FIFO_DEPTH));
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mem_req.addr <= 24'h000000;
    end else if (state == mfr_pkg::ST_ADDR && next_state == mfr_pkg::ST_MODE) begin
      mem_req.addr <= addr_next; // [RQ15]
    end else if (req_fire) begin
      mem_req.addr <= step_addr;
    end
  end

  // bytes still in flight when select rises belong to the dead read
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pend <= 4'h0;
      drop <= 4'h0;
    end else begin
      pend <= 4'(pend + {3'h0, req_fire} - {3'h0, rd_fire});
      if (cs_rise) begin
        drop <= 4'(pend + {3'h0, req_fire} - {3'h0, rd_fire});
      end else if (rd_fire && drop != 4'h0) begin
        drop <= drop - 4'h1;
      end
    end
  end

  assign push = rd_fire && drop == 4'h0 && !cs_rise;
  assign pop = state == mfr_pkg::ST_DATA && out_edge && unit_cnt == 5'h00 && !cs_high;

  mfr_byte_fifo #(
    .WIDTH(`MFR_FIFO_WIDTH),
    .DEPTH(`MFR_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .flush(cs_rise),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(mem_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_data),
    .level(fifo_level)
  );
  assign mem_rdata_ready = fifo_in_ready;

  // an underrun drives ones rather than stale bits
  assign cur_byte = (unit_cnt == 5'h00) ? (fifo_out_valid ? fifo_data : `MFR_DATA_IDLE) : out_byte;

  // drive starts at the first data edge, after the host let go
  always_ff @(posedge mclk) begin
    if (sys_rst || state != mfr_pkg::ST_DATA || cs_high) begin
      spi_io_drive.dout <= 4'h0;
      spi_io_drive.oe <= 4'h0; // [RQ5]
      out_byte <= 8'h00;
    end else if (out_edge) begin
      spi_io_drive.dout <= quad ? cur_byte[7:4] : {2'b00, cur_byte[7:6]}; // [RQ1] [RQ9]
      spi_io_drive.oe <= quad ? 4'hf : 4'h3;
      out_byte <= quad ? {cur_byte[3:0], 4'h0} : {cur_byte[5:0], 2'b00};
    end
  end

  // checking helpers
  always_ff @(posedge mclk) begin
    if (sys_rst || state == mfr_pkg::ST_MODE) begin
      dum_seen <= 5'h00;
    end else if (state == mfr_pkg::ST_DUMMY && rise) begin
      dum_seen <= dum_seen + 5'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_select_start;
    state == mfr_pkg::ST_IDLE && cs_fall;
  endsequence

  sequence s_mode_done;
    state == mfr_pkg::ST_MODE && samp_in && unit_cnt == mode_units - 5'h01 && !cs_high;
  endsequence

  a_cont_skip_opcode: assert property (s_select_start and continuation_active |=> state == mfr_pkg::ST_ADDR) // [RQ3]
    else $error("continuation entry did not go straight to address");
  a_cont_kind_kept: assert property (s_select_start and continuation_active |=> kind == $past(cont_kind)) // [RQ21]
    else $error("continuation entry changed the read kind");
  a_normal_opcode: assert property (s_select_start and !continuation_active |=> state == mfr_pkg::ST_OPCODE) // [RQ4]
    else $error("normal entry did not wait for an opcode");
  a_mode_nibble: assert property (s_mode_done |=> continuation_active == (mode_byte[5:4] == 2'b10)) // [RQ2]
    else $error("continuation flag disagrees with captured byte");
  a_quad_refused: assert property (state == mfr_pkg::ST_OPCODE && rise && unit_cnt == 5'h07 &&
    !cs_high && op_quad && op_read && !quad_io_permit_bit |=> state == mfr_pkg::ST_IGNORE) // [RQ10]
    else $error("quad read accepted without permit");
  a_quad_dummy: assert property ($rose(state == mfr_pkg::ST_DATA) && quad |-> dum_seen == 5'h04) // [RQ9]
    else $error("quad read did not pass four dummy clocks");
  a_dual_lanes: assert property (state == mfr_pkg::ST_DATA && !quad && spi_io_drive.oe != 4'h0
    |-> spi_io_drive.oe == 4'h3) // [RQ1]
    else $error("dual read drives wrong lines");
  a_dtr_fall_sample: assert property (state == mfr_pkg::ST_ADDR && dtr && fall && !cs_high &&
    unit_cnt != 5'h00
    |=> unit_cnt != $past(unit_cnt)) // [RQ19]
    else $error("double rate address ignored a falling edge");
  a_wrap_page: assert property (req_fire && wrap_on && fetching |=> mem_req.addr[23:6] == $past(mem_req.addr[23:6])) // [RQ14]
    else $error("wrap burst left its section");
  a_wrap_return: assert property (req_fire && wrap_on && fetching && (mem_req.addr[5:0] & wrap_mask) == wrap_mask
    |=> (mem_req.addr[5:0] & $past(wrap_mask)) == 6'h00) // [RQ15]
    else $error("wrap burst did not return to section start");
  a_linear_step: assert property (req_fire && !wrap_on && fetching |=> mem_req.addr == $past(mem_req.addr) + 24'h000001) // [RQ16]
    else $error("linear read did not step by one");
  a_wrap_default: assert property (@(posedge mclk) disable iff (1'b0)
    sys_rst |=> wrap_setting_bits == 3'b001) // [RQ18]
    else $error("wrap setting not disabled after reset");

endmodule

// [rtl/mfr_regs.svh]
/*
  Constants of the multi-I/O flash read front-end: opcodes, field
  positions, phase lengths, reset values and buffer shape.
  Assumes inclusion by bare name from the design files.
*/
`ifndef MFR_REGS_SVH
`define MFR_REGS_SVH

// opcodes
`define MFR_OP_DUAL 8'hbb
`define MFR_OP_DUAL_DTR 8'hbd
`define MFR_OP_QUAD 8'heb
`define MFR_OP_QUAD_DTR 8'hed
`define MFR_OP_WRAP_SET 8'h77

// phase lengths, in sampling units (one unit is one lane group)
`define MFR_OPCODE_UNITS 5'h08
`define MFR_ADDR_UNITS_DUAL 5'h0c
`define MFR_ADDR_UNITS_QUAD 5'h06
`define MFR_MODE_UNITS_DUAL 5'h04
`define MFR_MODE_UNITS_QUAD 5'h02
`define MFR_BYTE_UNITS_DUAL 5'h04
`define MFR_BYTE_UNITS_QUAD 5'h02
`define MFR_WRAP_SKIP_UNITS 5'h06
`define MFR_WRAP_BYTE_UNITS 5'h02

// dummy clocks between continuation byte and first data
`define MFR_DUMMY_DUAL 5'h00
`define MFR_DUMMY_DUAL_DTR 5'h00
`define MFR_DUMMY_QUAD 5'h04
`define MFR_DUMMY_QUAD_DTR 5'h04

// continuation byte fields
`define MFR_CONT_SEL_LO 4
`define MFR_CONT_SEL_KEEP 2'b10

// wrap byte fields; stored as {length[1:0], disable}
`define MFR_WRAP_FIELD_LO 4
`define MFR_WRAP_RESET 3'b001
`define MFR_WRAP_MASK_8 6'h07
`define MFR_WRAP_MASK_16 6'h0f
`define MFR_WRAP_MASK_32 6'h1f
`define MFR_WRAP_MASK_64 6'h3f

// read data buffer
`define MFR_FIFO_WIDTH 8
`define MFR_FIFO_DEPTH 8
`define MFR_DATA_IDLE 8'hff

`endif

// [rtl/mfr_pkg.sv]
/*
  Types of the multi-I/O flash read front-end: sequencer states, read
  kinds and the packed carriers for pin drive and fetch requests.
  Assumes nothing of its surroundings.
*/
package mfr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA,
    ST_WRAP_SKIP, ST_WRAP_BYTE, ST_IGNORE
  } mfr_state_e;

  typedef enum logic [1:0] {
    K_DUAL, K_DUAL_DTR, K_QUAD, K_QUAD_DTR
  } mfr_kind_e;

  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe;
  } mfr_pins_s;

  typedef struct packed {
    logic valid;
    logic [23:0] addr;
  } mfr_req_s;

endpackage

// [rtl/mfr_byte_fifo.sv]
/*
  Read data buffer between the memory array fetch and the pin shifter.
  Assumes one clock, synchronous active-high reset, and that flush is
  a single-cycle pulse from the same clock domain.
*/
`timescale 1ns/10ps
`include "mfr_regs.svh"

module mfr_byte_fifo #(
  parameter int WIDTH = `MFR_FIFO_WIDTH,
  parameter int DEPTH = `MFR_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] next_level;
  logic push;
  logic pop;

  assign out_valid = (level != '0);
  assign out_data = store[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    next_level = level;
    if (flush) begin
      next_level = '0;
    end else if (push && !pop) begin
      next_level = level + (AW+1)'(1);
    end else if (pop && !push) begin
      next_level = level - (AW+1)'(1);
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge mclk) begin
      if (push && wr_ptr == AW'(i)) begin
        store[i] <= in_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || flush) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || flush) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
    end
  end

  // ready is registered so the fill side never sees a combinational path
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      level <= '0;
      in_ready <= 1'b0;
    end else begin
      level <= next_level;
      in_ready <= (next_level != (AW+1)'(DEPTH));
    end
  end

endmodule

// [verif/mfr_host_model.sv]
/*
  Host controller model: drives select, serial clock and the IO lines,
  and reads bytes back. Assumes the bench resolves the shared IO wire.
*/
`timescale 1ns/10ps
module mfr_host_model (
  // pins
  output logic cs_n,
  output logic sclk,
  output logic [3:0] drv,
  output logic hoe,
  input wire logic [3:0] io
);
  logic [7:0] rx [8];

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    drv = 4'h0;
    hoe = 1'b1;
  end

  // levels of 40 ns keep each sclk level above 4 mclk
  task automatic unit(input logic [3:0] v, input bit dtr);
    if (dtr) begin
      drv = v;
      #20 sclk = ~sclk;
      #20;
    end else begin
      sclk = 1'b0;
      drv = v;
      #40 sclk = 1'b1;
      #40;
    end
  endtask

  task automatic sel();
    cs_n = 1'b0;
    hoe = 1'b1;
    #40;
  endtask

  // sclk is left where it is, it stands still between frames
  task automatic desel();
    #45 cs_n = 1'b1;
    #200;
  endtask

  // double rate units must start on a rising edge
  task automatic lead(input bit dtr);
    if (dtr && sclk) begin
      sclk = 1'b0;
      #40;
    end
  endtask

  task automatic op8(input logic [7:0] op);
    for (int i = 7; i >= 0; i--)
      unit({3'b000, op[i]}, 1'b0);
  endtask

  task automatic rd(input logic [7:0] op, input bit quad, dtr, skip,
                    input logic [23:0] a, input logic [7:0] m, input int nb);
    logic [31:0] s;
    int w;
    s = {a, m};
    w = quad ? 4 : 2;
    sel();
    if (!skip)
      op8(op);
    lead(dtr);
    for (int u = 0; u < 32 / w; u++) begin
      unit(quad ? s[31:28] : {2'b00, s[31:30]}, dtr);
      s = s << w;
    end
    repeat (quad ? 4 : 0) unit(4'h0, 1'b0);
    hoe = 1'b0;
    for (int b = 0; b < nb; b++) begin
      for (int u = 0; u < 8 / w; u++) begin
        sclk = dtr ? ~sclk : 1'b0;
        #45 rx[b] = quad ? {rx[b][3:0], io} : {rx[b][5:0], io[1:0]};
        if (!dtr) begin
          sclk = 1'b1;
          #45;
        end
      end
    end
    desel();
  endtask

  task automatic quit(input int n, input bit dtr);
    sel();
    lead(dtr);
    repeat (dtr ? 2 * n : n) unit(4'h1, dtr);
    desel();
  endtask

  task automatic wrap(input logic [7:0] wb);
    sel();
    op8(8'h77);
    repeat (6) unit(4'h0, 1'b0);
    unit(wb[7:4], 1'b0);
    unit(wb[3:0], 1'b0);
    desel();
  endtask
endmodule

// [verif/tb_top.sv]
/*
  Bench of the read front-end: host model on the pins, byte memory on
  the fetch side. Assumes the pin timing of the front-end's contract.
*/
`timescale 1ns/10ps
module tb_top;
  logic mclk;
  logic sys_rst = 1'b1;
  logic permit = 1'b0;
  logic cs_n;
  logic sclk;
  logic hoe;
  logic [3:0] drv;
  wire [3:0] io;
  mfr_pkg::mfr_pins_s pins;
  mfr_pkg::mfr_req_s req;
  logic req_rdy = 1'b0;
  logic [7:0] rdata = 8'h00;
  logic rvalid = 1'b0;
  logic rready;
  logic [2:0] wbits;
  logic cont;
  logic seen_oe = 1'b0;
  logic [7:0] mq [$];
  logic [7:0] ops [4] = '{8'hbb, 8'hbd, 8'heb, 8'hed};
  int n_errors = 0;
  int comparisons = 0;

  // a released line shows the inverse of its last value, not a guess
  assign io = (pins.oe & pins.dout) | (~pins.oe & (hoe ? drv : ~drv));

  mfr_host_model i_host (.cs_n(cs_n), .sclk(sclk), .drv(drv), .hoe(hoe), .io(io));

  mfr_read_front i_dut (.mclk(mclk), .sys_rst(sys_rst), .spi_cs_n(cs_n),
    .spi_sclk(sclk), .spi_io_in(io), .spi_io_drive(pins), .quad_io_permit_bit(permit),
    .wrap_setting_bits(wbits), .continuation_active(cont), .mem_req(req),
    .mem_req_ready(req_rdy), .mem_rdata(rdata), .mem_rdata_valid(rvalid),
    .mem_rdata_ready(rready));

  function automatic logic [7:0] img(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16];
  endfunction

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // memory: ready toggles so requests stall every other cycle
  always @(posedge mclk) begin
    if (rvalid && rready)
      void'(mq.pop_front());
    if (req.valid && req_rdy)
      mq.push_back(img(req.addr));
    if (pins.oe !== 4'h0)
      seen_oe = 1'b1;
    #1 req_rdy = ~req_rdy;
    rvalid = mq.size() > 0;
    rdata = mq.size() > 0 ? mq[0] : 8'h00;
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] op, input bit q, d, sk, input logic [23:0] a,
                      input logic [7:0] m, input int nb, input int s);
    logic [23:0] mk;
    logic [23:0] ea;
    mk = s > 0 ? 24'(s - 1) : 24'h0;
    i_host.rd(op, q, d, sk, a, m, nb);
    for (int i = 0; i < nb; i++) begin
      ea = s > 0 ? (a & ~mk) | ((a + 24'(i)) & mk) : a + 24'(i);
      chk(24'(i_host.rx[i]), 24'(img(ea)));
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #400000;
    n_errors++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge mclk);
    #1 sys_rst = 1'b0;
    chk(24'(wbits), 24'h1);
    chk(24'(cont), 24'h0);
    chk(24'(pins), 24'h0);
    $display("test reset done");
    permit = 1'b1;
    for (int k = 0; k < 4; k++) begin
      rchk(ops[k], k[1], k[0], 1'b0, 24'h001230 + 24'(k), 8'h2a, 3, 0);
      chk(24'(cont), 24'h1);
      rchk(ops[k], k[1], k[0], 1'b1, 24'h00a5f0 + 24'(k), 8'h25, 2, 0);
      chk(24'(cont), 24'h1);
      i_host.quit(k[1] ? 8 : 16, k[0]);
      chk(24'(cont), 24'h0);
      rchk(ops[k], k[1], k[0], 1'b0, 24'h0077fe, 8'h1f, 2, 0);
      chk(24'(cont), 24'h0);
    end
    $display("test read kinds done");
    permit = 1'b0;
    seen_oe = 1'b0;
    for (int k = 2; k < 4; k++)
      i_host.rd(ops[k], 1'b1, k[0], 1'b0, 24'h000100, 8'h20, 2);
    chk(24'(seen_oe), 24'h0);
    chk(24'(cont), 24'h0);
    permit = 1'b1;
    $display("test quad refusal done");
    for (int l = 0; l < 4; l++) begin
      i_host.wrap({1'b0, 2'(l), 5'h00});
      chk(24'(wbits), 24'(l * 2));
      rchk(ops[2 + l % 2], 1'b1, l[0], 1'b0, 24'h001240 + 24'((8 << l) - 2), 8'h00, 4,
           8 << l);
    end
    i_host.wrap(8'h70);
    chk(24'(wbits), 24'h7);
    rchk(8'heb, 1'b1, 1'b0, 1'b0, 24'h00127e, 8'h00, 4, 0);
    $display("test wrap done");
    final_report();
  end
endmodule
